// ### tpg_test_pattern_generator.sv
`timescale 1ns/100ps
// Contract
// - On-line position: no testing, only serial number and drive-type bits out
// - Tester position passes phase-encoded and density switches to clock generator
// - Tester present forces local-only asserted
// - Start-stop read repeats start, read one record, stop while switch raised
// - Start-stop write repeats start, write pattern record, stop while raised
// - Continuous write keeps drivers fed; motion left to maintenance panel
// - Eight-bit length counter preset from switches, used only by start-stop
// - Sixteen-bit pattern register from switch banks drives two data lines
// - Repetition interval adjustable; ninth length switch selects trim range
// - Read switch held closed (level, not edge) triggers first delay, which starts motion
// - First delay presets length counter and, in start-stop read only, loads pattern register
// - First delay expiry sets write-clock test enable flip-flop
// - Each record strobe advances counter and shifts pattern in start-stop
// - Counter overflow triggers third delay and drops write-clock enable
// - Third delay expiry starts fourth delay, which stops motion
// - Fourth delay expiry retriggers first delay while switch closed
// - Start-stop write asserts test write enable with write-clock enable
// - Start-stop write rotates pattern circularly on each strobe
// - Continuous write asserts both enables; inverted strobes shift pattern
// - Continuous write holds third delay inhibited
// - Only start-stop read loads pattern switches; continuous write shifts held pattern
// - Opening continuous switch clears its flip-flop and both enables
module tpg_test_pattern_generator (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Position and identity
	input wire logic tester_present_n,
	input wire logic [7:0] serial_wired,
	input wire logic [3:0] drive_type_wired,
	output logic [7:0] serial_out,
	output logic [3:0] drive_type_out,
	output logic local_only,
	// Mode switches
	input wire logic start_stop_read_sw,
	input wire logic start_stop_write_sw,
	input wire logic continuous_write_sw,
	input wire logic test_phase_encoded,
	input wire logic test_density_select,
	output logic test_phase_encoded_out,
	output logic test_density_select_out,
	// Setup switches
	input wire logic [7:0] length_switches,
	input wire logic length_range_sw,
	input wire logic [3:0] rate_trim,
	input wire logic [7:0] pattern_switches_low,
	input wire logic [7:0] pattern_switches_high,
	// Transport interface
	input wire logic record_strobe_n,
	output logic motion_start,
	output logic motion_stop,
	output logic write_clock_test_enable_n,
	output logic test_write_enable_n,
	output logic test_data_a,
	output logic test_data_b
);
	// ----------------------------------------
	// Synchronisers
	// ----------------------------------------
	logic [5:0] sync1_reg;
	logic [5:0] sync2_reg;
	logic [5:0] sync3_reg;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sync1_reg <= 6'h3F;
			sync2_reg <= 6'h3F;
			sync3_reg <= 6'h3F;
		end else begin
			sync1_reg <= {record_strobe_n, tester_present_n, continuous_write_sw,
				start_stop_write_sw, start_stop_read_sw, 1'b1};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end
	wire logic ssr_s = sync2_reg[1];
	wire logic ssw_s = sync2_reg[2];
	wire logic cw_s = sync2_reg[3];
	wire logic tester_on = ~sync2_reg[4];
	wire logic ssr_rise = sync2_reg[1] & ~sync3_reg[1];
	wire logic ssw_rise = sync2_reg[2] & ~sync3_reg[2];
	wire logic strobe_fall = ~sync2_reg[5] & sync3_reg[5];
	wire logic strobe_rise = sync2_reg[5] & ~sync3_reg[5];
	// ----------------------------------------
	// Position outputs
	// ----------------------------------------
	// identity, local-only flag and tester switch pass-through
	assign serial_out = serial_wired;
	assign drive_type_out = drive_type_wired;
	assign local_only = tester_on;
	assign test_phase_encoded_out = tester_on & test_phase_encoded;
	assign test_density_select_out = tester_on & test_density_select;
	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	tpg_pkg::tpg_state_t state_reg, state_next;
	logic [23:0] dly_reg, dly_next;
	logic [7:0] len_reg;
	logic [15:0] pat_reg;
	logic write_mode_reg;
	logic ss_active;
	wire logic ss_any = tester_on & (ssr_s | ssw_s) & ~cw_s;
	wire logic dly_done = (dly_reg == tpg_pkg::DLY_ONE);
	wire logic len_overflow = (len_reg == 8'hFF);
	wire logic [23:0] trim_cycles = length_range_sw ?
		24'({rate_trim, {tpg_pkg::TRIM_RANGE_SHIFT{1'b0}}}) * 24'(tpg_pkg::FOURTH_CYCLES >> 4) :
		24'(rate_trim) * 24'(tpg_pkg::FOURTH_CYCLES >> 4);
	wire logic [23:0] fourth_load = 24'(tpg_pkg::FOURTH_CYCLES) + trim_cycles;
	always_comb begin
		state_next = state_reg;
		dly_next = (dly_reg != tpg_pkg::DLY_ZERO) ? dly_reg - tpg_pkg::DLY_ONE : dly_reg;
		case (state_reg)
			tpg_pkg::TPG_IDLE: begin
				if (tester_on & cw_s) begin
					state_next = tpg_pkg::TPG_CONT;
				end else if (ss_any & (ssr_rise | ssw_rise | 1'b1)) begin
					state_next = tpg_pkg::TPG_FIRST;
					dly_next = 24'(tpg_pkg::FIRST_CYCLES);
				end
			end
			tpg_pkg::TPG_FIRST: begin
				if (dly_done) begin
					state_next = tpg_pkg::TPG_RECORD;
				end
			end
			tpg_pkg::TPG_RECORD: begin
				if (strobe_fall & len_overflow) begin
					state_next = tpg_pkg::TPG_THIRD;
					dly_next = 24'(tpg_pkg::THIRD_CYCLES);
				end
			end
			tpg_pkg::TPG_THIRD: begin
				if (dly_done) begin
					state_next = tpg_pkg::TPG_FOURTH;
					dly_next = fourth_load;
				end
			end
			tpg_pkg::TPG_FOURTH: begin
				if (dly_done) begin
					state_next = ss_any ? tpg_pkg::TPG_FIRST : tpg_pkg::TPG_IDLE;
					dly_next = 24'(tpg_pkg::FIRST_CYCLES);
				end
			end
			tpg_pkg::TPG_CONT: begin
				if (!(tester_on & cw_s)) begin
					state_next = tpg_pkg::TPG_IDLE;
				end
			end
			default: begin
				state_next = tpg_pkg::TPG_IDLE;
			end
		endcase
		if (!tester_on) begin
			state_next = tpg_pkg::TPG_IDLE;
		end
	end
	assign ss_active = (state_reg == tpg_pkg::TPG_RECORD);
	wire logic first_load = (state_reg == tpg_pkg::TPG_FIRST) & ~write_mode_reg;
	wire logic cont_on = (state_reg == tpg_pkg::TPG_CONT);
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= tpg_pkg::TPG_IDLE;
			dly_reg <= tpg_pkg::DLY_ZERO;
			write_mode_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			dly_reg <= dly_next;
			if (state_reg == tpg_pkg::TPG_IDLE) begin
				write_mode_reg <= ssw_s & ~ssr_s;
			end
		end
	end
	// ----------------------------------------
	// Length counter and pattern register
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			len_reg <= tpg_pkg::LEN_RESET;
			pat_reg <= tpg_pkg::PAT_RESET;
		end else begin
			if (state_reg == tpg_pkg::TPG_FIRST) begin
				len_reg <= length_switches;
			end else if (ss_active & strobe_fall) begin
				len_reg <= len_reg + 8'h01;
			end
			if (first_load) begin
				pat_reg <= {pattern_switches_high, pattern_switches_low};
			end else if ((ss_active & strobe_fall) | (cont_on & strobe_rise)) begin
				pat_reg <= {pat_reg[14:0], pat_reg[15]};
			end
		end
	end
	// ----------------------------------------
	// Outputs to transport
	// ----------------------------------------
	logic [5:0] out_reg;
	wire logic in_motion = (state_reg == tpg_pkg::TPG_FIRST) | ss_active
		| (state_reg == tpg_pkg::TPG_THIRD);
	wire logic wclk_en = ss_active | cont_on;
	wire logic wr_en = (ss_active & write_mode_reg) | cont_on;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			out_reg <= 6'h00;
		end else begin
			out_reg <= {in_motion, (state_reg == tpg_pkg::TPG_FOURTH), wclk_en, wr_en,
				pat_reg[15], pat_reg[7]};
		end
	end
	assign motion_start = out_reg[5];
	assign motion_stop = out_reg[4];
	assign write_clock_test_enable_n = ~out_reg[3];
	assign test_write_enable_n = ~out_reg[2];
	assign test_data_a = out_reg[1];
	assign test_data_b = out_reg[0];
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_local;
		@(posedge clk_sys) disable iff (!reset_n)
			$past(reset_n, 2) |-> (local_only == !$past(tester_present_n, 2));
	endproperty
	a_local: assert property (p_local) else $error("local not forced");
	property p_online_idle;
		@(posedge clk_sys) disable iff (!reset_n) !tester_on |=> ##1 !out_reg[3];
	endproperty
	a_online_idle: assert property (p_online_idle) else $error("test while on line");
	property p_first_en;
		@(posedge clk_sys) disable iff (!reset_n)
			(state_reg == tpg_pkg::TPG_FIRST) && dly_done && tester_on
			|=> ##1 !write_clock_test_enable_n;
	endproperty
	a_first_en: assert property (p_first_en) else $error("enable not set");
	property p_ovf;
		@(posedge clk_sys) disable iff (!reset_n)
			ss_active && strobe_fall && len_overflow |=> ##1 write_clock_test_enable_n;
	endproperty
	a_ovf: assert property (p_ovf) else $error("enable not dropped");
	property p_third;
		@(posedge clk_sys) disable iff (!reset_n)
			(state_reg == tpg_pkg::TPG_THIRD) && dly_done && tester_on |=> ##1 motion_stop;
	endproperty
	a_third: assert property (p_third) else $error("stop missing");
	property p_wr;
		@(posedge clk_sys) disable iff (!reset_n)
			ss_active && write_mode_reg |=> !test_write_enable_n;
	endproperty
	a_wr: assert property (p_wr) else $error("write enable missing");
	property p_cont;
		@(posedge clk_sys) disable iff (!reset_n)
			cont_on |=> !motion_start && !motion_stop && !write_clock_test_enable_n;
	endproperty
	a_cont: assert property (p_cont) else $error("third delay in continuous");
	property p_cont_len;
		@(posedge clk_sys) disable iff (!reset_n)
			cont_on |=> $stable(len_reg);
	endproperty
	a_cont_len: assert property (p_cont_len) else $error("counter used in continuous");
	property p_cont_off;
		@(posedge clk_sys) disable iff (!reset_n)
			cont_on && !cw_s |=> ##1 write_clock_test_enable_n && test_write_enable_n;
	endproperty
	a_cont_off: assert property (p_cont_off) else $error("enables kept after open");
	property p_preset;
		@(posedge clk_sys) disable iff (!reset_n)
			(state_reg == tpg_pkg::TPG_FIRST) |=> len_reg == $past(length_switches);
	endproperty
	a_preset: assert property (p_preset) else $error("length not preset");
	property p_load;
		@(posedge clk_sys) disable iff (!reset_n)
			first_load |=> pat_reg == {$past(pattern_switches_high), $past(pattern_switches_low)};
	endproperty
	a_load: assert property (p_load) else $error("pattern not loaded");
	property p_hold;
		@(posedge clk_sys) disable iff (!reset_n)
			(state_reg == tpg_pkg::TPG_FIRST) && write_mode_reg |=> $stable(pat_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("pattern loaded in write");
	property p_rot;
		@(posedge clk_sys) disable iff (!reset_n)
			ss_active && strobe_fall |=> pat_reg == {$past(pat_reg[14:0]), $past(pat_reg[15])};
	endproperty
	a_rot: assert property (p_rot) else $error("pattern not rotated");
	c_read: cover property (@(posedge clk_sys) state_reg == tpg_pkg::TPG_FOURTH && !write_mode_reg);
	c_write: cover property (@(posedge clk_sys) ss_active && write_mode_reg);
	c_cont: cover property (@(posedge clk_sys) cont_on && strobe_rise);
endmodule

// ### tpg_pkg.sv
package tpg_pkg;
	// ----------------------------------------
	// Sequencing delays
	// ----------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int FIRST_DELAY_US = 100;
	localparam int THIRD_DELAY_US = 100;
	localparam int FOURTH_DELAY_US = 100;
	localparam int FIRST_CYCLES = FIRST_DELAY_US * CLK_MHZ;
	localparam int THIRD_CYCLES = THIRD_DELAY_US * CLK_MHZ;
	localparam int FOURTH_CYCLES = FOURTH_DELAY_US * CLK_MHZ;
	localparam int DLY_W = 24;
	// ----------------------------------------
	// Widths and reset values
	// ----------------------------------------
	localparam int LEN_W = 8;
	localparam int PAT_W = 16;
	localparam int TRIM_W = 4;
	localparam int TRIM_RANGE_SHIFT = 4;
	localparam logic [7:0] LEN_RESET = 8'h00;
	localparam logic [15:0] PAT_RESET = 16'h0000;
	localparam logic [23:0] DLY_ZERO = 24'h000000;
	localparam logic [23:0] DLY_ONE = 24'h000001;
	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [2:0] {
		TPG_IDLE = 3'b000,
		TPG_FIRST = 3'b001,
		TPG_RECORD = 3'b010,
		TPG_THIRD = 3'b011,
		TPG_FOURTH = 3'b100,
		TPG_CONT = 3'b101
	} tpg_state_t;
endpackage

// ### tpg_slave_clock_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Slave clock model: record strobes
// ----------------------------------------
module tpg_slave_clock_model #(
	parameter int LOW_CYC = 6,
	parameter int HIGH_CYC = 10
) (
	// Clock
	input wire logic clk_sys,
	// Transport side
	input wire logic write_clock_test_enable_n,
	output logic record_strobe_n
);
	initial begin
		record_strobe_n = 1'b1;
		forever begin
			@(posedge clk_sys);
			if (write_clock_test_enable_n === 1'b0) begin
				repeat (HIGH_CYC) @(posedge clk_sys);
				if (write_clock_test_enable_n === 1'b0) begin
					record_strobe_n <= 1'b0;
					repeat (LOW_CYC) @(posedge clk_sys);
					record_strobe_n <= 1'b1;
				end
			end
		end
	end
endmodule

// ### tb.sv
`timescale 1ns/100ps
module tb;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic tester_present_n = 1'b1;
	logic start_stop_read_sw = 1'b0;
	logic start_stop_write_sw = 1'b0;
	logic length_range_sw = 1'b0;
	logic [3:0] rate_trim = 4'h0;
	int n_stop;
	logic continuous_write_sw = 1'b0;
	logic test_phase_encoded = 1'b1;
	logic test_density_select = 1'b0;
	logic [7:0] serial_out;
	logic [3:0] drive_type_out;
	logic local_only, test_phase_encoded_out, test_density_select_out;
	logic record_strobe_n, motion_start, motion_stop;
	logic write_clock_test_enable_n, test_write_enable_n, test_data_a, test_data_b;
	logic [15:0] p;
	int num_errors = 0;
	int samples_checked = 0;
	always #4 clk_sys = ~clk_sys;
	tpg_test_pattern_generator tpg_test_pattern_generator_inst (.clk_sys(clk_sys),
		.reset_n(reset_n), .tester_present_n(tester_present_n), .serial_wired(8'h5A),
		.drive_type_wired(4'h9), .serial_out(serial_out), .drive_type_out(drive_type_out),
		.local_only(local_only), .start_stop_read_sw(start_stop_read_sw),
		.start_stop_write_sw(start_stop_write_sw), .continuous_write_sw(continuous_write_sw),
		.test_phase_encoded(test_phase_encoded), .test_density_select(test_density_select),
		.test_phase_encoded_out(test_phase_encoded_out),
		.test_density_select_out(test_density_select_out), .length_switches(8'hFE),
		.length_range_sw(length_range_sw), .rate_trim(rate_trim), .pattern_switches_low(8'hC3),
		.pattern_switches_high(8'hA5), .record_strobe_n(record_strobe_n),
		.motion_start(motion_start), .motion_stop(motion_stop),
		.write_clock_test_enable_n(write_clock_test_enable_n),
		.test_write_enable_n(test_write_enable_n), .test_data_a(test_data_a),
		.test_data_b(test_data_b));
	tpg_slave_clock_model tpg_slave_clock_model_inst (.clk_sys(clk_sys),
		.write_clock_test_enable_n(write_clock_test_enable_n),
		.record_strobe_n(record_strobe_n));
	task automatic conclude();
		if (num_errors == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	function automatic logic cur(input int k);
		case (k)
			0: cur = motion_start;
			1: cur = motion_stop;
			2: cur = write_clock_test_enable_n;
			default: cur = record_strobe_n;
		endcase
	endfunction
	task automatic wait_sig(input int k, input logic v, input int bound);
		int n;
		n = 0;
		while (cur(k) !== v && n < bound) begin
			@(negedge clk_sys);
			n++;
		end
		if (cur(k) !== v) begin
			num_errors++;
			conclude();
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic chk_data();
		check(test_data_a, p[15]);
		check(test_data_b, p[7]);
	endtask
	// Start-stop record: load in read only, two strobes from preset FE, then stop
	task automatic run_record(input logic wr);
		wait_sig(2, 1'b0, 13000);
		check(test_write_enable_n, !wr);
		if (!wr) begin
			p = 16'hA5C3;
		end
		chk_data();
		for (int i = 0; i < 2; i++) begin
			wait_sig(3, 1'b0, 40);
			step(6);
			p = {p[14:0], p[15]};
			chk_data();
		end
		check(write_clock_test_enable_n, 1'b1);
		check(test_write_enable_n, 1'b1);
		wait_sig(1, 1'b1, 13000);
		check(motion_start, 1'b0);
	endtask
	initial begin
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		step(4);
		check(serial_out, 8'h5A);
		check(drive_type_out, 4'h9);
		check(local_only, 1'b0);
		check(test_phase_encoded_out, 1'b0);
		@(posedge clk_sys) tester_present_n <= 1'b0;
		step(4);
		check(local_only, 1'b1);
		check(test_phase_encoded_out, 1'b1);
		check(test_density_select_out, 1'b0);
		@(posedge clk_sys) start_stop_read_sw <= 1'b1;
		wait_sig(0, 1'b1, 10);
		run_record(1'b0);
		@(posedge clk_sys) start_stop_read_sw <= 1'b0;
		wait_sig(1, 1'b0, 13000);
		step(20);
		check(motion_start, 1'b0);
		@(posedge clk_sys) continuous_write_sw <= 1'b1;
		wait_sig(2, 1'b0, 10);
		check(test_write_enable_n, 1'b0);
		for (int i = 0; i < 2; i++) begin
			wait_sig(3, 1'b0, 40);
			wait_sig(3, 1'b1, 20);
			step(6);
			p = {p[14:0], p[15]};
			chk_data();
		end
		check(motion_start, 1'b0);
		@(posedge clk_sys) continuous_write_sw <= 1'b0;
		wait_sig(2, 1'b1, 10);
		check(test_write_enable_n, 1'b1);
		@(posedge clk_sys) begin
			start_stop_write_sw <= 1'b1;
			rate_trim <= 4'h1;
		end
		wait_sig(0, 1'b1, 10);
		run_record(1'b1);
		n_stop = 0;
		while (motion_stop === 1'b1 && n_stop < 14000) begin
			@(negedge clk_sys);
			n_stop++;
		end
		check(16'(n_stop), 16'(tpg_pkg::FOURTH_CYCLES + tpg_pkg::FOURTH_CYCLES / 16));
		check(motion_start, 1'b1);
		@(posedge clk_sys) begin
			reset_n <= 1'b0;
			start_stop_write_sw <= 1'b0;
		end
		step(1);
		check({motion_start, motion_stop, write_clock_test_enable_n, test_write_enable_n}, 4'h3);
		check({test_data_a, test_data_b}, 2'h0);
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		step(4);
		check(local_only, 1'b1);
		check(motion_start, 1'b0);
		@(posedge clk_sys) begin
			test_phase_encoded <= 1'b0;
			test_density_select <= 1'b1;
		end
		step(1);
		check(test_phase_encoded_out, 1'b0);
		check(test_density_select_out, 1'b1);
		conclude();
	end
endmodule
